//--- rtl/usc_pkg.sv
// Constants and types of the serial channel status and command block.
// Assumes a 32-bit AHB-Lite register window decoded on the low address byte.
package usc_pkg;

  // ********************************************************************
  // Register byte offsets.
  // ********************************************************************
  localparam logic [7:0] USC_OFF_SC   = 8'h00;
  localparam logic [7:0] USC_OFF_MODE = 8'h04;
  localparam logic [7:0] USC_OFF_IST  = 8'h08;
  localparam logic [7:0] USC_OFF_IMSK = 8'h0C;
  localparam logic [7:0] USC_OFF_TXH  = 8'h10;
  localparam logic [7:0] USC_OFF_RXH  = 8'h14;

  // ********************************************************************
  // Field positions and write codes.
  // ********************************************************************
  localparam int         USC_F_OVW    = 6;
  localparam int         USC_F_MDEP   = 4;
  localparam int         USC_F_TXH    = 2;
  localparam int         USC_F_RXH    = 0;
  localparam int         USC_MODE_LSB = 3;
  localparam logic [1:0] USC_WR_CLR   = 2'h2;
  localparam logic [1:0] USC_WR_SET   = 2'h3;
  localparam logic [1:0] USC_PW_CLRE  = 2'h1;

  // ********************************************************************
  // Interrupt bits and reset values.
  // ********************************************************************
  localparam int         USC_IRQ_RX   = 0;
  localparam int         USC_IRQ_TX   = 1;
  localparam int         USC_IRQ_OVW  = 2;
  localparam int         USC_IRQ_EOT  = 3;
  localparam int         USC_IRQ_W    = 4;
  localparam logic       USC_TXE_RST  = 1'h1;
  localparam logic       USC_VAL_RST  = 1'h0;
  localparam logic [2:0] USC_ME_RST   = 3'h0;

  typedef enum logic [1:0] {
    USC_DISABLED,
    USC_RS232,
    USC_PWIRE,
    USC_TTC
  } usc_mode_t;

endpackage

//--- rtl/usc_reg_if.sv
// Internal register strobe carrier between the bus slave and the register file.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface usc_reg_if;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport slave (output wr, output rd, output addr, output wdata, input rdata);
  modport regs  (input wr, input rd, input addr, input wdata, output rdata);
endinterface

//--- rtl/usc_ahb_slave.sv
// AHB-Lite slave front end: turns bus transfers into one-cycle strobes.
// Assumes single word transfers; reads take one wait state, writes none.
`timescale 1ns/100ps
module usc_ahb_slave (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  usc_reg_if.slave         bus
);
  logic       accept;
  logic       dp_wr;
  logic       dp_rd;
  logic [7:0] dp_addr;
  logic       rd_go;

  assign accept    = hsel && htrans[1] && hready;
  assign rd_go     = dp_rd && !hreadyout;
  assign bus.wr    = dp_wr && hreadyout;
  assign bus.rd    = rd_go;
  assign bus.addr  = dp_addr;
  assign bus.wdata = hwdata;

  // ********************************************************************
  // Data phase tracking.
  // ********************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_wr   <= 1'b0;
      dp_rd   <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready) begin
      dp_wr <= accept && hwrite;
      dp_rd <= accept && !hwrite;
      if (accept) begin
        dp_addr <= haddr;
      end
    end
  end

  // The wait state lets a read see the effect of a write just before it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (accept && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_go) begin
        hreadyout <= 1'b1;
        hrdata    <= bus.rdata;
      end
    end
  end
endmodule

//--- rtl/usc_top.sv
// Status and command register of one extra serial channel, with interrupt.
// Assumes the shifters, divider and FIFO of the channel sit outside.
`timescale 1ns/100ps
module usc_top
  import usc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              rx_word_valid,
  input  wire logic [DATA_W-1:0] rx_word_data,
  input  wire logic              rx_ninth_bit,
  input  wire logic              rx_fifo_assoc,
  input  wire logic              rx_fifo_full,
  input  wire logic              tx_hold_loaded,
  output logic      [DATA_W-1:0] tx_hold_data,
  output logic                   tx_hold_write,
  output logic                   rx_hold_read,
  input  wire logic              line_valid_in,
  output logic                   line_valid_out,
  output logic                   line_valid_oe_n,
  output logic                   transfer_start,
  output usc_mode_t              channel_mode,
  output logic      [2:0]        mode_ext,
  output logic                   irq
);

  // Data words must fit the 32-bit bus word and hold at least one byte.
  if (DATA_W < 8 || DATA_W > 32) begin : g_width_check
    $error("DATA_W must lie between 8 and 32");
  end

  // ********************************************************************
  // Reset release and bus front end.
  // ********************************************************************
  logic [1:0] rst_pipe;
  logic       rst_n;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  usc_reg_if bus ();

  usc_ahb_slave u_slave (
    .clk       (clk_sys),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr[7:0]),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hwdata    (hwdata),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .bus       (bus.slave)
  );

  // ********************************************************************
  // Decode.
  // ********************************************************************
  logic              sc_wr;
  logic              txh_wr;
  logic              rxh_rd;
  logic [1:0]        f_ovw;
  logic [1:0]        f_md;
  logic [1:0]        f_tx;
  logic [1:0]        f_rx;
  logic              is_rs;
  logic              is_pw;
  logic              pw_tx;
  logic              ttc_master;
  logic              obs_level;
  logic              obs_q;
  logic              fall;
  logic              ovw_ev;
  logic              ovw;
  logic              rx_full;
  logic              tx_empty;
  logic              xfer_end;
  logic              ninth;
  logic [DATA_W-1:0] rx_hold;
  logic [1:0]        md_rd;
  logic [7:0]        sc_rd;
  logic [USC_IRQ_W-1:0] ev;
  logic [USC_IRQ_W-1:0] ist;
  logic [USC_IRQ_W-1:0] imsk;

  assign sc_wr  = bus.wr && bus.addr == USC_OFF_SC;
  assign txh_wr = bus.wr && bus.addr == USC_OFF_TXH;
  assign rxh_rd = bus.rd && bus.addr == USC_OFF_RXH;
  assign f_ovw  = bus.wdata[USC_F_OVW +: 2];
  assign f_md   = bus.wdata[USC_F_MDEP +: 2];
  assign f_tx   = bus.wdata[USC_F_TXH +: 2];
  assign f_rx   = bus.wdata[USC_F_RXH +: 2];
  assign is_rs      = channel_mode == USC_RS232;
  assign is_pw      = channel_mode == USC_PWIRE;
  assign pw_tx      = is_pw && mode_ext[0];
  assign ttc_master = channel_mode == USC_TTC && mode_ext[2];

  // In transmit the block drives the line itself, so it watches its own drive.
  assign obs_level = pw_tx ? line_valid_out : line_valid_in;
  assign fall      = is_pw && obs_q && !obs_level;
  assign ovw_ev    = rx_word_valid && (rx_full || (rx_fifo_assoc && rx_fifo_full));

  // ********************************************************************
  // Mode register.
  // ********************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      channel_mode <= USC_DISABLED;
      mode_ext     <= USC_ME_RST;
    end else if (bus.wr && bus.addr == USC_OFF_MODE) begin
      channel_mode <= usc_mode_t'(bus.wdata[USC_MODE_LSB +: 2]);
      mode_ext     <= bus.wdata[2:0];
    end
  end

  // ********************************************************************
  // Status flags. Hardware events win over software clears.
  // ********************************************************************
  // overwrite flag
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ovw <= 1'b0;
    end else if (ovw_ev || (sc_wr && f_ovw == USC_WR_SET)) begin
      ovw <= 1'b1;
    end else if (sc_wr && f_ovw == USC_WR_CLR) begin
      ovw <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_full <= 1'b0;
    end else if (rx_word_valid || (sc_wr && f_rx == USC_WR_SET)) begin
      rx_full <= 1'b1;
    end else if (rxh_rd || (sc_wr && f_rx == USC_WR_CLR)) begin
      rx_full <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_empty <= USC_TXE_RST;
    end else if (tx_hold_loaded || (sc_wr && f_tx == USC_WR_SET)) begin
      tx_empty <= 1'b1;
    end else if (txh_wr || (sc_wr && f_tx == USC_WR_CLR)) begin
      tx_empty <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      xfer_end <= 1'b0;
      obs_q    <= USC_VAL_RST;
    end else begin
      obs_q <= obs_level;
      if (fall) begin
        xfer_end <= 1'b1;
      end else if (sc_wr && is_pw && f_md == USC_PW_CLRE) begin
        xfer_end <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_valid_out  <= USC_VAL_RST;
      line_valid_oe_n <= 1'b1;
    end else begin
      line_valid_oe_n <= !pw_tx;
      if (sc_wr && pw_tx && f_md[1]) begin
        line_valid_out <= f_md[0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      transfer_start <= 1'b0;
    end else begin
      transfer_start <= sc_wr && ttc_master && f_md == USC_WR_SET;
    end
  end

  // ********************************************************************
  // Data hold registers. A new word always replaces an unread one.
  // ********************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_hold       <= '0;
      ninth         <= 1'b0;
      tx_hold_data  <= '0;
      tx_hold_write <= 1'b0;
      rx_hold_read  <= 1'b0;
    end else begin
      tx_hold_write <= txh_wr;
      rx_hold_read  <= rxh_rd;
      if (rx_word_valid) begin
        rx_hold <= rx_word_data;
        ninth   <= rx_ninth_bit;
      end
      if (txh_wr) begin
        tx_hold_data <= bus.wdata[DATA_W-1:0];
      end
    end
  end

  // ********************************************************************
  // Interrupts: sticky status, write one to clear, masked onto irq.
  // ********************************************************************
  assign ev[USC_IRQ_RX]  = rx_word_valid;
  assign ev[USC_IRQ_TX]  = tx_hold_loaded;
  assign ev[USC_IRQ_OVW] = ovw_ev;
  assign ev[USC_IRQ_EOT] = fall;

  for (genvar i = 0; i < USC_IRQ_W; i++) begin : g_ist
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        ist[i] <= 1'b0;
      end else if (ev[i]) begin
        ist[i] <= 1'b1;
      end else if (bus.wr && bus.addr == USC_OFF_IST && bus.wdata[i]) begin
        ist[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      imsk <= '0;
      irq  <= 1'b0;
    end else begin
      irq <= |(ist & imsk);
      if (bus.wr && bus.addr == USC_OFF_IMSK) begin
        imsk <= bus.wdata[USC_IRQ_W-1:0];
      end
    end
  end

  // ********************************************************************
  // Read back.
  // ********************************************************************
  always_comb begin
    case (channel_mode)
      USC_RS232: md_rd = {1'b0, ninth};
      USC_PWIRE: md_rd = {xfer_end, !obs_level};
      default:   md_rd = 2'h0;
    endcase
  end

  assign sc_rd = {1'b0, ovw, md_rd, 1'b0, tx_empty, 1'b0, rx_full};

  always_comb begin
    case (bus.addr)
      USC_OFF_SC:   bus.rdata = 32'(sc_rd);
      USC_OFF_MODE: bus.rdata = 32'({channel_mode, mode_ext});
      USC_OFF_IST:  bus.rdata = 32'(ist);
      USC_OFF_IMSK: bus.rdata = 32'(imsk);
      USC_OFF_TXH:  bus.rdata = 32'(tx_hold_data);
      USC_OFF_RXH:  bus.rdata = 32'(rx_hold);
      default:      bus.rdata = 32'h0000_0000;
    endcase
  end

  // ********************************************************************
  // Checks.
  // ********************************************************************
  AST_OVW_OVERRUN: assert property (rx_word_valid && rx_full |=> ovw)
    else $error("overwrite flag missed an overrun");
  AST_OVW_FIFO: assert property (rx_word_valid && rx_fifo_assoc && rx_fifo_full |=> ovw)
    else $error("overwrite flag missed a full FIFO");
  AST_RS232_NINTH: assert property (is_rs && rx_word_valid |=> sc_rd[4] == $past(rx_ninth_bit))
    else $error("ninth bit not shown in RS232 mode");
  AST_PW_DROP: assert property (sc_wr && pw_tx && f_md == USC_WR_CLR |=> !line_valid_out)
    else $error("valid line not dropped");
  AST_PW_RX_KEEP: assert property (sc_wr && is_pw && !pw_tx && f_md[1] && !fall
      |=> xfer_end == $past(xfer_end) && $stable(line_valid_out))
    else $error("receive mode write changed end flag or line");
  AST_EOR_LOW: assert property (is_pw |-> sc_rd[4] != obs_level)
    else $error("valid level not read inverted");
  AST_EOR_FALL: assert property (is_pw && $fell(obs_level) |=> xfer_end)
    else $error("end flag missed a falling edge");
  AST_EOR_HOLD: assert property (xfer_end && !sc_wr |=> xfer_end)
    else $error("end flag dropped without software");
  AST_BOT_START: assert property (sc_wr && ttc_master && f_md == USC_WR_SET
      |=> transfer_start ##1 !transfer_start)
    else $error("start trigger not a single pulse");
  AST_BOT_SLAVE: assert property (transfer_start |-> $past(ttc_master))
    else $error("start trigger outside master mode");
  AST_TI_CLR: assert property (sc_wr && f_tx == USC_WR_CLR && !tx_hold_loaded
      |=> !tx_empty)
    else $error("transmit flag not cleared");
  AST_TI_NEVER_1X: assert property (!sc_rd[USC_F_TXH + 1] && !sc_rd[USC_F_RXH + 1])
    else $error("flag field read 1X");
  AST_RI_KEEP: assert property (sc_wr && !f_rx[1] && !rx_word_valid && !rxh_rd
      |=> $stable(rx_full))
    else $error("receive flag changed on 0X");
  AST_RI_FULL: assert property (rx_word_valid |=> sc_rd[USC_F_RXH +: 2] == 2'h1)
    else $error("receive field not 01 after a word");
  AST_RX_READ: assert property (rxh_rd && !rx_word_valid
      |=> !rx_full && rx_hold_read ##1 !rx_hold_read)
    else $error("receive read did not clear flag");
  AST_TX_WRITE: assert property (txh_wr && !tx_hold_loaded |=> !tx_empty && tx_hold_write)
    else $error("transmit write did not clear flag");
  AST_RESET_VAL: assert property ($rose(rst_n) |-> tx_empty && !ovw && !rx_full
      && !xfer_end && line_valid_out == USC_VAL_RST)
    else $error("bad state after reset");
  AST_IRQ: assert property (|(ist & imsk) |=> irq)
    else $error("interrupt not raised");

endmodule

//--- bench/usc_peer.sv
// Model of the remote serial peer and channel data path around the register.
// Assumes the bench calls its tasks; all outputs change right after a rising edge.
`timescale 1ns/100ps
module usc_peer (
  input  wire logic        clk_sys,
  output logic             rx_word_valid,
  output logic      [15:0] rx_word_data,
  output logic             rx_ninth_bit,
  output logic             rx_fifo_assoc,
  output logic             rx_fifo_full,
  output logic             tx_hold_loaded,
  output logic             line_valid_in
);
  // ********************************************************************
  // Idle levels.
  // ********************************************************************
  initial begin
    rx_word_valid  = 1'b0;
    rx_word_data   = 16'h0000;
    rx_ninth_bit   = 1'b0;
    rx_fifo_assoc  = 1'b0;
    rx_fifo_full   = 1'b0;
    tx_hold_loaded = 1'b0;
    line_valid_in  = 1'b0;
  end

  // ********************************************************************
  // Peer actions.
  // ********************************************************************
  // A received word is a one-cycle pulse; data is inverted once the pulse ends,
  // so a design that samples late sees the wrong word.
  task automatic send(input logic [15:0] d, input logic b9);
    @(posedge clk_sys);
    rx_word_valid <= 1'b1;
    rx_word_data  <= d;
    rx_ninth_bit  <= b9;
    @(posedge clk_sys);
    rx_word_valid <= 1'b0;
    rx_word_data  <= ~d;
    rx_ninth_bit  <= ~b9;
  endtask

  task automatic load_tx();
    @(posedge clk_sys);
    tx_hold_loaded <= 1'b1;
    @(posedge clk_sys);
    tx_hold_loaded <= 1'b0;
  endtask

  task automatic fifo(input logic assoc, input logic full);
    @(posedge clk_sys);
    rx_fifo_assoc <= assoc;
    rx_fifo_full  <= full;
  endtask

  task automatic line(input logic v);
    @(posedge clk_sys);
    line_valid_in <= v;
  endtask
endmodule

//--- bench/usc_top_test.sv
// Self-checking bench of the serial channel status and command register.
// Assumes one clock, an AHB-Lite master in the bench and the peer model.
`timescale 1ns/100ps
module usc_top_test;
  import usc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp;
  logic        rx_word_valid, rx_ninth_bit, rx_fifo_assoc, rx_fifo_full;
  logic        tx_hold_loaded, line_valid_in, tx_hold_write, rx_hold_read;
  logic        line_valid_out, line_valid_oe_n, transfer_start, irq;
  logic [15:0] rx_word_data, tx_hold_data;
  logic [2:0]  mode_ext;
  usc_mode_t   channel_mode;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  int          starts      = 0;
  int          tx_writes   = 0;
  int          rx_reads    = 0;

  always #2 clk_sys = ~clk_sys;

  usc_top i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_word_valid(rx_word_valid),
    .rx_word_data(rx_word_data), .rx_ninth_bit(rx_ninth_bit), .rx_fifo_assoc(rx_fifo_assoc),
    .rx_fifo_full(rx_fifo_full), .tx_hold_loaded(tx_hold_loaded),
    .tx_hold_data(tx_hold_data), .tx_hold_write(tx_hold_write),
    .rx_hold_read(rx_hold_read), .line_valid_in(line_valid_in),
    .line_valid_out(line_valid_out), .line_valid_oe_n(line_valid_oe_n),
    .transfer_start(transfer_start), .channel_mode(channel_mode), .mode_ext(mode_ext),
    .irq(irq));

  usc_peer i_peer (.clk_sys(clk_sys), .rx_word_valid(rx_word_valid),
    .rx_word_data(rx_word_data), .rx_ninth_bit(rx_ninth_bit),
    .rx_fifo_assoc(rx_fifo_assoc), .rx_fifo_full(rx_fifo_full),
    .tx_hold_loaded(tx_hold_loaded), .line_valid_in(line_valid_in));

  // ********************************************************************
  // Helpers.
  // ********************************************************************
  // The limit sits far above the few hundred cycles the scenarios need.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (transfer_start === 1'b1) starts <= starts + 1;
    if (tx_hold_write === 1'b1) tx_writes <= tx_writes + 1;
    if (rx_hold_read === 1'b1) rx_reads <= rx_reads + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // The master holds each phase until it samples ready high at a rising edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? wd : ~wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    xfer(1'b1, a, d, unused);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] got;
    xfer(1'b0, a, 32'h0, got);
    chk(what, exp, got);
  endtask

  // ********************************************************************
  // Scenarios.
  // ********************************************************************
  task automatic t_reset();
    rd_chk("status after reset", USC_OFF_SC, 32'h04);
    chk("valid level after reset", 32'h0, 32'(line_valid_out));
    chk("valid enable after reset", 32'h1, 32'(line_valid_oe_n));
    chk("bus response", 32'h0, 32'(hresp));
    rd_chk("unmapped read", 8'h20, 32'h0);
  endtask

  task automatic t_rs232();
    wr(USC_OFF_MODE, 32'h08);
    rd_chk("mode readback", USC_OFF_MODE, 32'h08);
    chk("mode pins", 32'h08, 32'({channel_mode, mode_ext}));
    i_peer.send(16'h1234, 1'b1);
    rd_chk("status first word", USC_OFF_SC, 32'h15);
    wr(USC_OFF_SC, 32'h30);
    rd_chk("ninth bit write ignored", USC_OFF_SC, 32'h15);
    i_peer.send(16'h4321, 1'b0);
    rd_chk("overwrite on unread", USC_OFF_SC, 32'h45);
    wr(USC_OFF_SC, 32'h01);
    rd_chk("rx field keep", USC_OFF_SC, 32'h45);
    rd_chk("rx hold data", USC_OFF_RXH, 32'h4321);
    rd_chk("rx full cleared by read", USC_OFF_SC, 32'h44);
    chk("rx hold read pulses", 32'h1, rx_reads);
    wr(USC_OFF_SC, 32'h80);
    rd_chk("overwrite clear", USC_OFF_SC, 32'h04);
    wr(USC_OFF_SC, 32'hC0);
    rd_chk("overwrite set", USC_OFF_SC, 32'h44);
    wr(USC_OFF_SC, 32'h80);
  endtask

  task automatic t_fifo_irq();
    wr(USC_OFF_IST, 32'h0F);
    wr(USC_OFF_IMSK, 32'h04);
    tick(2);
    chk("irq idle", 32'h0, 32'(irq));
    i_peer.fifo(1'b1, 1'b1);
    i_peer.send(16'h0055, 1'b0);
    tick(3);
    chk("irq on overwrite", 32'h1, 32'(irq));
    rd_chk("overwrite on fifo full", USC_OFF_SC, 32'h45);
    rd_chk("irq status", USC_OFF_IST, 32'h05);
    wr(USC_OFF_IST, 32'h04);
    tick(2);
    chk("irq after clear", 32'h0, 32'(irq));
    i_peer.fifo(1'b0, 1'b0);
    rd_chk("rx hold fifo word", USC_OFF_RXH, 32'h0055);
    wr(USC_OFF_SC, 32'h80);
    wr(USC_OFF_IMSK, 32'h00);
  endtask

  task automatic t_tx();
    wr(USC_OFF_TXH, 32'hA5);
    rd_chk("tx full after hold write", USC_OFF_SC, 32'h00);
    chk("tx hold data", 32'hA5, 32'(tx_hold_data));
    chk("tx hold write pulses", 32'h1, tx_writes);
    i_peer.load_tx();
    tick(2);
    rd_chk("tx empty after load", USC_OFF_SC, 32'h04);
    wr(USC_OFF_SC, 32'h08);
    rd_chk("tx field clear", USC_OFF_SC, 32'h00);
    wr(USC_OFF_SC, 32'h04);
    rd_chk("tx field keep", USC_OFF_SC, 32'h00);
    wr(USC_OFF_SC, 32'h0C);
    rd_chk("tx field set", USC_OFF_SC, 32'h04);
  endtask

  task automatic t_pw_tx();
    wr(USC_OFF_MODE, 32'h11);
    wr(USC_OFF_SC, 32'h30);
    tick(2);
    chk("valid driven high", 32'h1, 32'(line_valid_out));
    chk("valid enable", 32'h0, 32'(line_valid_oe_n));
    rd_chk("valid read inverted", USC_OFF_SC, 32'h04);
    wr(USC_OFF_SC, 32'h20);
    tick(2);
    chk("valid driven low", 32'h0, 32'(line_valid_out));
    rd_chk("end flag on fall", USC_OFF_SC, 32'h34);
    wr(USC_OFF_SC, 32'h00);
    rd_chk("no change code", USC_OFF_SC, 32'h34);
    wr(USC_OFF_SC, 32'h10);
    rd_chk("end flag clear tx", USC_OFF_SC, 32'h14);
  endtask

  task automatic t_pw_rx();
    wr(USC_OFF_MODE, 32'h10);
    i_peer.line(1'b1);
    tick(2);
    rd_chk("line high inverted", USC_OFF_SC, 32'h04);
    i_peer.line(1'b0);
    tick(2);
    rd_chk("end flag rx fall", USC_OFF_SC, 32'h34);
    wr(USC_OFF_SC, 32'h20);
    wr(USC_OFF_SC, 32'h30);
    rd_chk("rx codes 1X keep", USC_OFF_SC, 32'h34);
    wr(USC_OFF_SC, 32'h10);
    rd_chk("end flag clear rx", USC_OFF_SC, 32'h14);
    chk("no drive in rx", 32'h1, 32'(line_valid_oe_n));
  endtask

  task automatic t_ttc();
    int n0;
    wr(USC_OFF_MODE, 32'h1C);
    n0 = starts;
    wr(USC_OFF_SC, 32'h20);
    wr(USC_OFF_SC, 32'h10);
    tick(2);
    chk("no start on 0X X0", n0, starts);
    wr(USC_OFF_SC, 32'h30);
    tick(2);
    chk("master start", n0 + 1, starts);
    wr(USC_OFF_MODE, 32'h18);
    wr(USC_OFF_SC, 32'h30);
    tick(2);
    chk("slave start ignored", n0 + 1, starts);
    rd_chk("ttc field reads 00", USC_OFF_SC, 32'h04);
  endtask

  // ********************************************************************
  // Main sequence.
  // ********************************************************************
  initial begin
    tick(12);
    reset_n <= 1'b1;
    tick(3);
    t_reset();
    t_rs232();
    t_fifo_irq();
    t_tx();
    t_pw_tx();
    t_pw_rx();
    t_ttc();
    stop_test();
  end
endmodule
